// ==== gput_core_if.sv ====
/*
  link between the register side and the counter side of the timer.
  assumes one driver per signal, set by the modports.
*/
`timescale 1ns/10ps
interface gput_core_if;
    logic [15:0] ctl;
    logic [15:0] load;
    logic [1:0] clrBits;
    logic applyCtl;
    logic applyClr;
    logic [15:0] count;
    logic [15:0] capVal;
    logic [1:0] flags;
    logic tmoEvt;
    modport host
    (
        output ctl, load, clrBits, applyCtl, applyClr,
        input count, capVal, flags, tmoEvt
    );
    modport timer
    (
        input ctl, load, clrBits, applyCtl, applyClr,
        output count, capVal, flags, tmoEvt
    );
endinterface

// ==== gput_counter.sv ====
/*
  timer side: prescaler, 16-bit up/down counter, timeout and capture flags.
  assumes source enables are single-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/10ps
module gput_counter
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // clock source enables
    input wire logic tickCore,
    input wire logic tickLowFreqOsc,
    input wire logic tickFastCrystal,
    input wire logic tickFastInternalOsc,
    input wire logic fastCrystalSel,
    // capture event sources
    input wire logic [gput_pkg::EVT_N-1:0] eventIn,
    // register side
    gput_core_if.timer core
);
    import gput_pkg::*;
    typedef struct packed {
        logic [15:0] ctl;
        logic [14:0] pre;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic tmo;
        logic capF;
    } gput_tmr_s;
    gput_tmr_s s_r, s_nxt;
    logic en, up, periodic, srcTick, tick, terminal, tmoEvt, grab;
    logic [1:0] src;
    logic [14:0] preTc;
    logic [15:0] startVal, newStart;

    always_comb
    begin
        s_nxt = s_r;
        en = s_r.ctl[CTL_ENABLE_BIT];
        up = s_r.ctl[CTL_UP_BIT];
        periodic = s_r.ctl[CTL_RUN_STYLE_BIT];
        src = s_r.ctl[CTL_CLKSEL_LSB +: 2];
        case (src) // R12
            SRC_BUS: srcTick = 1'b1;
            SRC_CORE: srcTick = tickCore;
            SRC_LOW: srcTick = tickLowFreqOsc;
            default: srcTick = fastCrystalSel ? tickFastCrystal : tickFastInternalOsc;
        endcase
        case (s_r.ctl[CTL_PRE_LSB +: 2]) // R16
            2'h0: preTc = (src == SRC_BUS || src == SRC_CORE) ? PRE_TC_4 : PRE_TC_1;
            2'h1: preTc = PRE_TC_16;
            2'h2: preTc = PRE_TC_256;
            default: preTc = PRE_TC_32K;
        endcase
        tick = en && srcTick && (s_r.pre >= preTc);
        terminal = up ? (s_r.cnt == CNT_FULL) : (s_r.cnt == CNT_ZERO);
        tmoEvt = tick && terminal;
        // reload in periodic mode, wrap in free-running mode
        startVal = periodic ? core.load : (up ? CNT_ZERO : CNT_FULL); // R6 R15
        if (en && srcTick)
            s_nxt.pre = (s_r.pre >= preTc) ? PRE_TC_1 : s_r.pre + 15'h0001;
        if (tick)
            s_nxt.cnt = terminal ? startVal : (up ? s_r.cnt + 16'h0001 : s_r.cnt - 16'h0001);
        if (core.applyClr)
        begin
            if (core.clrBits[CLR_TMO_BIT])
            begin
                s_nxt.tmo = 1'b0; // R5
                if (periodic && s_r.ctl[CTL_RELOAD_CLR_BIT])
                    s_nxt.cnt = core.load; // R11
            end
            if (core.clrBits[CLR_CAP_BIT])
                s_nxt.capF = 1'b0; // R17
        end
        if (tmoEvt)
            s_nxt.tmo = 1'b1; // R5
        // first event wins; held until cleared
        grab = s_r.ctl[CTL_GRAB_EN_BIT] && eventIn[s_r.ctl[CTL_EVSEL_LSB +: 4]]; // R9 R10
        if (grab && !s_nxt.capF)
        begin
            s_nxt.capF = 1'b1; // R4 R17
            s_nxt.cap = s_r.cnt; // R9
        end
        newStart = core.ctl[CTL_RUN_STYLE_BIT] ? core.load :
                   (core.ctl[CTL_UP_BIT] ? CNT_ZERO : CNT_FULL);
        if (core.applyCtl)
        begin
            s_nxt.ctl = core.ctl;
            if (!core.ctl[CTL_ENABLE_BIT])
            begin
                s_nxt.cnt = CNT_ZERO; // R14
                s_nxt.pre = PRE_TC_1;
            end
            else if (!en)
            begin
                s_nxt.cnt = newStart; // R15
                s_nxt.pre = PRE_TC_1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.ctl <= CTL_RESET;
        end
        else
            s_r <= s_nxt;
    end

    assign core.count = s_r.cnt;
    assign core.capVal = s_r.cap;
    assign core.flags = {s_r.capF, s_r.tmo};
    assign core.tmoEvt = tmoEvt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_tmo_set: // R5
        assert property (tmoEvt |=> s_r.tmo)
        else $error("timeout flag not set at terminal count");
    a_periodic_reload: // R6
        assert property (tmoEvt && periodic && !core.applyCtl && !core.applyClr |=> s_r.cnt == $past(core.load))
        else $error("periodic reload missed");
    a_capture_take: // R9
        assert property (grab && !s_r.capF && !core.applyCtl |=> s_r.capF && s_r.cap == $past(s_r.cnt))
        else $error("capture did not take the count");
    a_capture_hold: // R17
        assert property (s_r.capF && !core.applyClr |=> s_r.capF && $stable(s_r.cap))
        else $error("capture overwritten before clear");
    a_disable_reset: // R14
        assert property (core.applyCtl && !core.ctl[CTL_ENABLE_BIT] |=> s_r.cnt == CNT_ZERO ##1 s_r.cnt == CNT_ZERO)
        else $error("disabled timer not held at zero");
endmodule

// ==== gput_hs_sync.sv ====
/*
  toggle handshake carrying one request into the timer side and its
  acknowledge back. assumes start is raised only while busy is low.
*/
`timescale 1ns/10ps
module gput_hs_sync
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // request and answer
    input wire logic start,
    output logic deliver,
    output logic busy
);
    import gput_pkg::*;
    typedef struct packed {
        logic reqT;
        logic d1;
        logic d2;
        logic d3;
        logic a1;
        logic a2;
    } gput_hs_s;
    gput_hs_s s_r, s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.reqT = s_r.reqT ^ start;
        s_nxt.d1 = s_r.reqT;
        s_nxt.d2 = s_r.d1;
        s_nxt.d3 = s_r.d2;
        s_nxt.a1 = s_r.d3;
        s_nxt.a2 = s_r.a1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign deliver = s_r.d2 ^ s_r.d3;
    assign busy = s_r.reqT ^ s_r.a2;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_hs_deliver: // R19
        assert property (start |-> ##3 deliver ##1 !deliver)
        else $error("handshake did not deliver once");
    a_hs_busy: // R19
        assert property (start |=> busy [*5] ##1 !busy)
        else $error("handshake busy span wrong");
endmodule

// ==== gput_pkg.sv ====
/*
  constants shared by the up/down timer: register addresses, field positions,
  reset values and prescaler terminal counts.
  assumes a 32-bit byte-addressed register bus.
*/
package gput_pkg;
    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [31:0] ADR_FIRST_STATUS = 32'h4000001C;
    localparam logic [31:0] ADR_LOAD = 32'h40000400;
    localparam logic [31:0] ADR_COUNT = 32'h40000404;
    localparam logic [31:0] ADR_CONTROL = 32'h40000408;
    localparam logic [31:0] ADR_IRQ_CLEAR = 32'h4000040C;
    localparam logic [31:0] ADR_CAPTURE = 32'h40000410;
    localparam logic [31:0] ADR_STATUS = 32'h4000041C;
    localparam logic [31:0] ADR_IRQ_STA = 32'h40000420;
    localparam logic [31:0] ADR_IRQ_MASK = 32'h40000424;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTL_GRAB_EN_BIT = 12;
    localparam int CTL_EVSEL_LSB = 8;
    localparam int CTL_RELOAD_CLR_BIT = 7;
    localparam int CTL_CLKSEL_LSB = 5;
    localparam int CTL_ENABLE_BIT = 4;
    localparam int CTL_RUN_STYLE_BIT = 3;
    localparam int CTL_UP_BIT = 2;
    localparam int CTL_PRE_LSB = 0;
    localparam logic [15:0] CTL_RESET = 16'h000A;
    localparam logic [15:0] CTL_WMASK = 16'h1FFF;
    // ----------------------------------------
    // status, clear and interrupt fields
    // ----------------------------------------
    localparam int STA_CLEAR_SYNC_PENDING_BIT = 7;
    localparam int STA_BUSY_BIT = 6;
    localparam int STA_CAP_BIT = 1;
    localparam int STA_TMO_BIT = 0;
    localparam int CLR_CAP_BIT = 1;
    localparam int CLR_TMO_BIT = 0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ----------------------------------------
    // clock sources, prescaler, counter limits
    // ----------------------------------------
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_CORE = 2'h1;
    localparam logic [1:0] SRC_LOW = 2'h2;
    localparam logic [14:0] PRE_TC_1 = 15'h0000;
    localparam logic [14:0] PRE_TC_4 = 15'h0003;
    localparam logic [14:0] PRE_TC_16 = 15'h000F;
    localparam logic [14:0] PRE_TC_256 = 15'h00FF;
    localparam logic [14:0] PRE_TC_32K = 15'h7FFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam int EVT_N = 16;
    localparam int SYNC_LAG = 2;
endpackage

// ==== gput_timer.sv ====
/*
  16-bit up/down timer with capture, behind a classic Wishbone slave.
  assumes all inputs synchronous to clk_sys; clock sources arrive as enables.
*/
// The Wishbone register port was decided locally.
// Operation
// (R1) Writing one to timeout clear sets clear-pending until the clear takes effect.
// (R2) Busy stays high while a control write is crossing to the timer side.
// (R3) Software waits for busy low before writing control again.
// (R4) Status capture bit reads one while a captured event is pending.
// (R5) Timeout flag sets at terminal count, clears on timeout-clear write.
// (R6) Periodic mode reloads counter from load register every period.
// (R7) Load writes during a timeout event are applied after it.
// (R8) Count register shows the counter two cycles late.
// (R9) With capture enabled, a selected event copies the count to capture.
// (R10) Four-bit selector picks one of sixteen event sources.
// (R11) Periodic with reload-on-clear: timeout clear also reloads the counter.
// (R12) Two-bit field selects bus, core, low-frequency or fast clock.
// (R13) Control resets to 0x000A, other registers to zero; the interrupt mask resets to 0x3 instead.
// (R14) Enable runs the timer; clearing it stops and zeroes it.
// (R15) Mode picks periodic or free-running start; direction picks up or down.
// (R16) Prescaler divides by 1 or 4, 16, 256 or 32768.
// (R17) Capture holds until capture-clear write; both clear bits write-one.
// (R18) Interrupt high while timeout or capture flag is set; here a flag's rise is latched, and the mask or a status write-one drops irq.
// (R19) Control and clear requests cross through handshake synchronisers.
`timescale 1ns/10ps
module gput_timer
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone slave
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // clock source enables and clock config
    input wire logic tickCore,
    input wire logic tickLowFreqOsc,
    input wire logic tickFastCrystal,
    input wire logic tickFastInternalOsc,
    input wire logic fastCrystalSel,
    // capture event sources
    input wire logic [gput_pkg::EVT_N-1:0] eventIn,
    // interrupt
    output logic irq
);
    import gput_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [15:0] load;
        logic [15:0] loadAct;
        logic loadPend;
        logic [15:0] ctl;
        logic ctlQ;
        logic [1:0] clrQ;
        logic [1:0] clrF;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [1:0] flg1;
        logic [1:0] flg2;
        logic [1:0] flg3;
        logic [1:0] irqSta;
        logic [1:0] irqMask;
        logic irq;
    } gput_bus_s;
    gput_bus_s s_r, s_nxt;

    gput_core_if core();
    logic ctlStart, ctlBusy, clrStart, clrBusy;
    logic reqNew, wrCycle, busyStat, clrPend;
    logic [15:0] staVal;
    logic [31:0] rdVal;
    logic [1:0] evtRise, flagFall;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
            r[7:0] = d[7:0];
        if (sel[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // ----------------------------------------
    // crossings into the timer side
    // ----------------------------------------
    gput_hs_sync ctlSync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(ctlStart),
        .deliver(core.applyCtl),
        .busy(ctlBusy)
    );

    gput_hs_sync clrSync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(clrStart),
        .deliver(core.applyClr),
        .busy(clrBusy)
    );

    gput_counter tmr
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tickCore(tickCore),
        .tickLowFreqOsc(tickLowFreqOsc),
        .tickFastCrystal(tickFastCrystal),
        .tickFastInternalOsc(tickFastInternalOsc),
        .fastCrystalSel(fastCrystalSel),
        .eventIn(eventIn),
        .core(core.timer)
    );

    assign core.ctl = s_r.ctl;
    assign core.load = s_r.loadAct;
    assign core.clrBits = s_r.clrF;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        reqNew = cyc_i && stb_i && !s_r.ack;
        wrCycle = cyc_i && stb_i && s_r.ack && we_i;
        busyStat = s_r.ctlQ || ctlBusy; // R2
        clrPend = s_r.clrQ[CLR_TMO_BIT] || (s_r.clrF[CLR_TMO_BIT] && clrBusy); // R1
        ctlStart = s_r.ctlQ && !ctlBusy; // R19
        clrStart = (|s_r.clrQ) && !clrBusy; // R19
        staVal = REG_RESET;
        staVal[STA_CLEAR_SYNC_PENDING_BIT] = clrPend;
        staVal[STA_BUSY_BIT] = busyStat;
        staVal[STA_CAP_BIT] = s_r.flg2[STA_CAP_BIT]; // R4
        staVal[STA_TMO_BIT] = s_r.flg2[STA_TMO_BIT];

        // read mux; unmapped and write-only addresses read zero
        rdVal = '0;
        case (adr_i)
            ADR_LOAD: rdVal[15:0] = s_r.load;
            ADR_COUNT: rdVal[15:0] = s_r.cnt2; // R8
            ADR_CONTROL: rdVal[15:0] = s_r.ctl;
            ADR_CAPTURE: rdVal[15:0] = s_r.cap2;
            ADR_STATUS: rdVal[15:0] = staVal;
            ADR_FIRST_STATUS: rdVal[15:0] = staVal;
            ADR_IRQ_STA: rdVal[1:0] = s_r.irqSta;
            ADR_IRQ_MASK: rdVal[1:0] = s_r.irqMask;
            default: rdVal = '0;
        endcase

        // one-cycle answer, dropped after one cycle
        s_nxt.ack = reqNew;
        if (reqNew)
            s_nxt.dat = rdVal;

        // launches free the queues before new writes refill them
        if (ctlStart)
            s_nxt.ctlQ = 1'b0;
        if (clrStart)
        begin
            s_nxt.clrF = s_r.clrQ;
            s_nxt.clrQ = 2'h0;
        end

        // held load goes live once no timeout is under way
        if (s_r.loadPend && !core.tmoEvt)
        begin
            s_nxt.loadAct = s_r.load; // R7
            s_nxt.loadPend = 1'b0;
        end

        // flags and values from the timer side
        s_nxt.cnt1 = core.count; // R8
        s_nxt.cnt2 = s_r.cnt1;
        s_nxt.cap1 = core.capVal;
        s_nxt.cap2 = s_r.cap1;
        s_nxt.flg1 = core.flags;
        s_nxt.flg2 = s_r.flg1;
        s_nxt.flg3 = s_r.flg2;
        evtRise = s_r.flg2 & ~s_r.flg3;
        flagFall = s_r.flg3 & ~s_r.flg2;
        s_nxt.irqSta = s_r.irqSta & ~flagFall;

        if (wrCycle)
        begin
            case (adr_i)
                ADR_LOAD:
                begin
                    s_nxt.load = merge16(s_r.load, dat_i, sel_i);
                    s_nxt.loadPend = 1'b1; // R7
                end
                ADR_CONTROL:
                begin
                    s_nxt.ctl = merge16(s_r.ctl, dat_i, sel_i) & CTL_WMASK;
                    s_nxt.ctlQ = 1'b1; // R2
                end
                ADR_IRQ_CLEAR:
                    if (sel_i[0])
                        s_nxt.clrQ = s_nxt.clrQ | dat_i[1:0]; // R1 R17
                ADR_IRQ_STA:
                    if (sel_i[0])
                        s_nxt.irqSta = s_nxt.irqSta & ~dat_i[1:0];
                ADR_IRQ_MASK:
                    if (sel_i[0])
                        s_nxt.irqMask = dat_i[1:0];
                default:
                    s_nxt.irqMask = s_nxt.irqMask;
            endcase
        end

        // a new event beats a clear in the same cycle
        s_nxt.irqSta = s_nxt.irqSta | evtRise; // R18
        s_nxt.irq = |(s_nxt.irqSta & s_nxt.irqMask); // R18
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_r <= '0; // R13
            s_r.ctl <= CTL_RESET; // R13
            s_r.irqMask <= IRQ_MASK_RESET;
        end
        else
            s_r <= s_nxt;
    end

    assign dat_o = s_r.dat;
    assign ack_o = s_r.ack;
    assign irq = s_r.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ack_single:
        assert property (cyc_i && stb_i && !s_r.ack |=> s_r.ack ##1 !s_r.ack)
        else $error("bus answer not a single cycle");
    a_busy_raise: // R2
        assert property (wrCycle && adr_i == ADR_CONTROL |=> busyStat [*6])
        else $error("busy not held after control write");
    a_clear_sync_pending_raise: // R1
        assert property (wrCycle && adr_i == ADR_IRQ_CLEAR && sel_i[0] && dat_i[0] |=> clrPend)
        else $error("clear pending not raised");
    a_clear_sync_pending_drop: // R1
        assert property ($fell(clrPend) |-> !clrBusy && !s_r.clrQ[CLR_TMO_BIT])
        else $error("clear pending dropped before completion");
    a_count_lag: // R8
        assert property (##2 s_r.cnt2 == $past(core.count, 2))
        else $error("count register lag is not two cycles");
    a_load_defer: // R7
        assert property (s_r.loadPend && core.tmoEvt |=> $stable(s_r.loadAct))
        else $error("load applied during timeout");
    a_irq_timeout: // R18
        assert property ($rose(s_r.flg2[STA_TMO_BIT]) && s_r.irqMask[STA_TMO_BIT] |=> irq)
        else $error("timeout did not raise interrupt");
    a_ctl_reset: // R13
        assert property ($rose(rst_n) |-> s_r.ctl == CTL_RESET && s_r.load == REG_RESET)
        else $error("reset values wrong");
endmodule

// ==== tb.sv ====
/*
  self-checking bench for gput_timer: register reset values, control and clear
  crossings, periodic timeout, interrupt mask and clear, capture on every source.
  assumes the design's own assertions run alongside; clock sources other than
  the bus clock stay idle.
*/
`timescale 1ns/10ps
module tb;
import gput_pkg::*;
typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] e;} gput_row_s;
// ----------------------------------------
// stimulus and bookkeeping
// ----------------------------------------
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic [31:0] busAdr = 32'h0;
logic [31:0] busWdat = 32'h0;
logic [3:0] busSel = 4'hF;
logic busWe = 1'b0;
logic busCyc = 1'b0;
logic busStb = 1'b0;
logic [31:0] busRdat;
logic busAck;
logic [15:0] eventIn = 16'h0;
logic irq;
int errTotal = 0;
int numChecks = 0;
int cycCnt = 0;
logic [31:0] q;
logic [31:0] capV;
gput_row_s rows [12];
always #50 clk_sys = ~clk_sys;
gput_timer dut_u
(
    .clk_sys(clk_sys), .rst_n(rst_n), .adr_i(busAdr), .dat_i(busWdat), .sel_i(busSel),
    .we_i(busWe), .cyc_i(busCyc), .stb_i(busStb), .dat_o(busRdat), .ack_o(busAck),
    .tickCore(1'b0), .tickLowFreqOsc(1'b0), .tickFastCrystal(1'b0),
    .tickFastInternalOsc(1'b0), .fastCrystalSel(1'b0), .eventIn(eventIn), .irq(irq)
);
// ----------------------------------------
// shared tasks
// ----------------------------------------
task give_verdict();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
        errTotal++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask
// one classic cycle; request held until ack is sampled high
task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    busAdr <= a;
    busWe <= w;
    busWdat <= d;
    busCyc <= 1'b1;
    busStb <= 1'b1;
    do
    begin
        @(posedge clk_sys);
        n++;
    end
    while (busAck !== 1'b1 && n < 50);
    r = busRdat;
    busCyc <= 1'b0;
    busStb <= 1'b0;
    if (n >= 50)
        chk("bus ack", 32'h0, 32'h1);
endtask
task automatic waitSta(input int b, input logic v, output logic [31:0] r);
    int n;
    n = 0;
    do
    begin
        wb(ADR_STATUS, 1'b0, 32'h0, r);
        n++;
    end
    while (r[b] !== v && n < 60);
endtask
task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys);
    eventIn <= v;
    @(posedge clk_sys);
    eventIn <= 16'h0;
    repeat (4) @(posedge clk_sys);
endtask
task automatic waitIrq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 400)
    begin
        @(posedge clk_sys);
        n++;
    end
endtask
// hang guard
always @(posedge clk_sys)
begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 30000)
    begin
        errTotal++;
        give_verdict();
    end
end
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    rows = '{'{ADR_LOAD, 0, 0, 0}, '{ADR_COUNT, 0, 0, 0}, '{ADR_CONTROL, 0, 0, 32'(CTL_RESET)},
        '{ADR_CAPTURE, 0, 0, 0}, '{ADR_STATUS, 0, 0, 0}, '{ADR_FIRST_STATUS, 0, 0, 0},
        '{ADR_IRQ_STA, 0, 0, 0}, '{ADR_IRQ_MASK, 0, 0, 32'(IRQ_MASK_RESET)},
        '{32'h40000430, 1, 32'h1234, 0}, '{ADR_COUNT, 1, 32'h55, 0},
        '{ADR_CAPTURE, 1, 32'h77, 0}, '{ADR_LOAD, 1, 32'h40, 32'h40}};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
        if (rows[i].w)
            wb(rows[i].a, 1'b1, rows[i].d, q);
        wb(rows[i].a, 1'b0, 32'h0, q);
        chk("register readback", q, rows[i].e);
    end
    // periodic, down, bus clock divided by four, enabled
    wb(ADR_CONTROL, 1'b1, 32'h18, q);
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    chk("busy after control write", 32'(q[STA_BUSY_BIT]), 32'h1);
    waitSta(STA_BUSY_BIT, 1'b0, q);
    chk("busy drops", 32'(q[STA_BUSY_BIT]), 32'h0);
    waitIrq(1'b1);
    chk("irq on timeout", 32'(irq), 32'h1);
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    chk("timeout flag", 32'(q[STA_TMO_BIT]), 32'h1);
    wb(ADR_COUNT, 1'b0, 32'h0, q);
    chk("count within period", 32'(q <= 32'h40), 32'h1);
    // mask, clear pending interrupt, then clear the timeout flag
    wb(ADR_IRQ_MASK, 1'b1, 32'h0, q);
    wb(ADR_IRQ_STA, 1'b1, 32'h3, q);
    repeat (3) @(posedge clk_sys);
    chk("irq after w1c", 32'(irq), 32'h0);
    wb(ADR_IRQ_CLEAR, 1'b1, 32'h1, q);
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    chk("clear pending set", 32'(q[STA_CLEAR_SYNC_PENDING_BIT]), 32'h1);
    waitSta(STA_CLEAR_SYNC_PENDING_BIT, 1'b0, q);
    chk("clear pending drops", 32'(q[STA_CLEAR_SYNC_PENDING_BIT]), 32'h0);
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    chk("timeout cleared", 32'(q[STA_TMO_BIT]), 32'h0);
    repeat (300) @(posedge clk_sys);
    chk("masked irq", 32'(irq), 32'h0);
    wb(ADR_IRQ_STA, 1'b0, 32'h0, q);
    chk("masked event recorded", 32'(q[0]), 32'h1);
    wb(ADR_IRQ_MASK, 1'b1, 32'h3, q);
    waitIrq(1'b1);
    chk("unmasked irq", 32'(irq), 32'h1);
    wb(ADR_IRQ_STA, 1'b1, 32'h3, q);
    wb(ADR_IRQ_CLEAR, 1'b1, 32'h1, q);
    // disable stops and zeroes the counter
    wb(ADR_CONTROL, 1'b1, 32'h0, q);
    waitSta(STA_BUSY_BIT, 1'b0, q);
    repeat (4) @(posedge clk_sys);
    wb(ADR_COUNT, 1'b0, 32'h0, q);
    chk("count after disable", q, 32'h0);
    // capture on every source, free-running up
    for (int s = 0; s < EVT_N; s++)
    begin
        wb(ADR_CONTROL, 1'b1, 32'h1014 | (s << CTL_EVSEL_LSB), q);
        waitSta(STA_BUSY_BIT, 1'b0, q);
        repeat (8) @(posedge clk_sys);
        pulse(~(16'h1 << s));
        wb(ADR_STATUS, 1'b0, 32'h0, q);
        chk("other sources ignored", 32'(q[STA_CAP_BIT]), 32'h0);
        pulse(16'h1 << s);
        wb(ADR_STATUS, 1'b0, 32'h0, q);
        chk("capture pending", 32'(q[STA_CAP_BIT]), 32'h1);
        wb(ADR_CAPTURE, 1'b0, 32'h0, capV);
        chk("capture nonzero", 32'(capV != 32'h0), 32'h1);
        repeat (20) @(posedge clk_sys);
        pulse(16'h1 << s);
        wb(ADR_CAPTURE, 1'b0, 32'h0, q);
        chk("capture held", q, capV);
        chk("irq on capture", 32'(irq), 32'h1);
        wb(ADR_IRQ_CLEAR, 1'b1, 32'h2, q);
        waitSta(STA_CAP_BIT, 1'b0, q);
        chk("capture cleared", 32'(q[STA_CAP_BIT]), 32'h0);
        wb(ADR_IRQ_STA, 1'b1, 32'h3, q);
    end
    // capture disabled
    wb(ADR_CONTROL, 1'b1, 32'h0514, q);
    waitSta(STA_BUSY_BIT, 1'b0, q);
    pulse(16'h0020);
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    chk("no capture when disabled", 32'(q[STA_CAP_BIT]), 32'h0);
    // periodic down with reload-on-clear: a timeout clear pulls the count back to load
    wb(ADR_CONTROL, 1'b1, 32'h98, q);
    waitSta(STA_BUSY_BIT, 1'b0, q);
    wb(ADR_IRQ_CLEAR, 1'b1, 32'h1, q);
    waitSta(STA_CLEAR_SYNC_PENDING_BIT, 1'b0, q);
    wb(ADR_COUNT, 1'b0, 32'h0, q);
    chk("reload on clear", 32'(q <= 32'h40 && q >= 32'h38), 32'h1);
    // reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(ADR_CONTROL, 1'b0, 32'h0, q);
    chk("control after reset", q, 32'(CTL_RESET));
    wb(ADR_COUNT, 1'b0, 32'h0, q);
    chk("count after reset", q, 32'h0);
    give_verdict();
end
endmodule
